// ---- scc_cfg.svh ----
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_NCH 16
`define SCC_NPAIR 8
`define SCC_NTMR 2
`define SCC_TW 16
`define SCC_AW 8
`define SCC_OFF_TCTRL 8'h00
`define SCC_OFF_T0CNT 8'h04
`define SCC_OFF_T0REL 8'h08
`define SCC_T_STRIDE 8
`define SCC_OFF_DBL 8'h14
`define SCC_OFF_PINS 8'h18
`define SCC_REG_GLB 2'h0
`define SCC_REG_CFG 2'h1
`define SCC_REG_VAL 2'h2
`define SCC_RG_HI 7
`define SCC_RG_LO 6
`define SCC_IX_HI 5
`define SCC_IX_LO 2
`define SCC_TC_STRIDE 8
`define SCC_TC_W 4
`define SCC_TC_STAG 16
`define SCC_TC_BITS 17
`define SCC_CFG_W 7
`define SCC_PRE_W 9
`define SCC_DIV8_B 3
`define SCC_DIV64_B 6
`define SCC_DIV512_B 9
`define SCC_RESP_OK 2'h0
`define SCC_RESP_ERR 2'h2
`endif

// ---- scc_pkg.sv ----
`default_nettype none
package scc_pkg;
   typedef enum logic [2:0] {
      SCC_OFF = 3'h0,
      SCC_CAP = 3'h1,
      SCC_CMP0 = 3'h2,
      SCC_CMP1 = 3'h3,
      SCC_CMP2 = 3'h4,
      SCC_CMP3 = 3'h5
   } scc_mode_e;
   typedef enum logic [2:0] {
      SCC_DIV1 = 3'h0,
      SCC_DIV8 = 3'h1,
      SCC_DIV64 = 3'h2,
      SCC_DIV512 = 3'h3,
      SCC_GPT = 3'h4,
      SCC_EXT = 3'h5
   } scc_src_e;
   typedef struct packed {
      logic single;
      logic tsel;
      logic [1:0] edge_sel;
      scc_mode_e mode;
   } scc_ch_cfg_s;
   typedef struct packed {
      scc_src_e src;
      logic run;
   } scc_tmr_cfg_s;
endpackage
`default_nettype wire

// ---- scc_top.sv ----
// Contract
// - sixteen capture/compare channels, one system clock resolution normally.
// - staggered operation coarsens timer resolution to eight system clocks.
// - two independent 16-bit timers, each with its own reload register.
// - timer clock chosen from prescaled system clock or general timer pulse.
// - timers may count external count input edges.
// - each channel picks its timer and capture or compare operation.
// - one pin per channel: capture input or compare output.
// - capture event copies assigned timer count into channel register.
// - each capture raises that channel's interrupt request.
// - capture edge selectable rising, falling or both.
// - compare channels checked each timer step; match runs mode action.
// - mode 0 interrupt only, many per period.
// - mode 1 toggles pin on each match, many per period.
// - mode 2 interrupt only, at most one per period.
// - mode 3 sets pin on match, clears on overflow, once per period.
// - double register: two channels share a pin, toggling on either match.
// - single event option stops a compare channel after its first match; capture channels keep capturing.
`timescale 1ns/10ps
`include "scc_cfg.svh"
`default_nettype none
module scc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [`SCC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`SCC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic gpt_ovf_pulse,
   input wire logic [`SCC_NTMR-1:0] ext_count_in,
   input wire logic [`SCC_NCH-1:0] cc_pin_in,
   output logic [`SCC_NCH-1:0] cc_pin_out,
   output logic [`SCC_NCH-1:0] cc_pin_oe_n,
   output logic [`SCC_NCH-1:0] cc_irq_req
);
   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic [`SCC_AW-1:0] aw_addr_ff;
   logic aw_full_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic w_full_ff;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, w_map, r_map;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff, rd_data;

   wire aw_hs = s_axi_awvalid & awready_ff;
   wire w_hs = s_axi_wvalid & wready_ff;
   wire wr_do = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire ar_hs = s_axi_arvalid & arready_ff;
   wire nxt_aw_full = aw_hs | (aw_full_ff & ~wr_do);
   wire nxt_w_full = w_hs | (w_full_ff & ~wr_do);
   wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
      end
      else if (ce)
      begin
         aw_full_ff <= nxt_aw_full;
         w_full_ff <= nxt_w_full;
         awready_ff <= ~nxt_aw_full;
         wready_ff <= ~nxt_w_full;
         arready_ff <= ~nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_addr_ff <= '0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `SCC_RESP_OK;
         rdata_ff <= '0;
         rresp_ff <= `SCC_RESP_OK;
      end
      else if (ce)
      begin
         if (aw_hs)
            aw_addr_ff <= s_axi_awaddr;
         if (w_hs)
         begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff <= w_map ? `SCC_RESP_OK : `SCC_RESP_ERR;
         end
         else if (s_axi_bready)
            bvalid_ff <= 1'b0;
         if (ar_hs)
         begin
            rdata_ff <= rd_data;
            rresp_ff <= r_map ? `SCC_RESP_OK : `SCC_RESP_ERR;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // ----------------------------------------------------------------
   // address decode and byte lanes
   // ----------------------------------------------------------------
   wire [1:0] w_reg = aw_addr_ff[`SCC_RG_HI:`SCC_RG_LO];
   wire [3:0] w_idx = aw_addr_ff[`SCC_IX_HI:`SCC_IX_LO];
   wire [`SCC_AW-1:0] w_off = {aw_addr_ff[`SCC_AW-1:`SCC_IX_LO], 2'h0};
   wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
   wire w_glb = wr_do & (w_reg == `SCC_REG_GLB);
   wire wr_tctrl = w_glb & (w_off == `SCC_OFF_TCTRL);
   wire wr_dbl = w_glb & (w_off == `SCC_OFF_DBL);
   assign w_map = (w_reg == `SCC_REG_CFG) | (w_reg == `SCC_REG_VAL) | glb_hit(w_off);

   wire [1:0] r_reg = s_axi_araddr[`SCC_RG_HI:`SCC_RG_LO];
   wire [3:0] r_idx = s_axi_araddr[`SCC_IX_HI:`SCC_IX_LO];
   wire [`SCC_AW-1:0] r_off = {s_axi_araddr[`SCC_AW-1:`SCC_IX_LO], 2'h0};
   assign r_map = (r_reg == `SCC_REG_CFG) | (r_reg == `SCC_REG_VAL) | glb_hit(r_off);

   function automatic logic glb_hit(input logic [`SCC_AW-1:0] off);
      glb_hit = (off <= `SCC_OFF_PINS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
      merge = (old & ~m) | (d & m);
   endfunction

   // ----------------------------------------------------------------
   // global control
   // ----------------------------------------------------------------
   logic [`SCC_TC_BITS-1:0] tctrl_ff;
   logic [`SCC_NPAIR-1:0] dbl_ff;
   logic [`SCC_PRE_W-1:0] pre_ff;
   logic gpt_prev_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tctrl_ff <= '0;
         dbl_ff <= '0;
         pre_ff <= '0;
         gpt_prev_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_tctrl)
            tctrl_ff <= `SCC_TC_BITS'(merge(32'(tctrl_ff), w_data_ff, wmask));
         if (wr_dbl)
            dbl_ff <= `SCC_NPAIR'(merge(32'(dbl_ff), w_data_ff, wmask));
         pre_ff <= pre_ff + 1'b1;
         gpt_prev_ff <= gpt_ovf_pulse;
      end
   end

   wire stag = tctrl_ff[`SCC_TC_STAG];
   wire hit8 = (pre_ff[`SCC_DIV8_B-1:0] == '0);
   wire hit64 = (pre_ff[`SCC_DIV64_B-1:0] == '0);
   wire hit512 = (pre_ff[`SCC_DIV512_B-1:0] == '0);
   // the general timer flags each overflow with a pulse; count its rising edge only
   wire gpt_hit = gpt_ovf_pulse & ~gpt_prev_ff;

   // ----------------------------------------------------------------
   // time bases
   // ----------------------------------------------------------------
   wire [`SCC_TW-1:0] tcnt [`SCC_NTMR];
   wire [`SCC_TW-1:0] trel [`SCC_NTMR];
   wire [`SCC_NTMR-1:0] tfresh;
   wire [`SCC_NTMR-1:0] tovf;

   genvar t;
   generate
      for (t = 0; t < `SCC_NTMR; t++)
      begin : g_tmr
         localparam logic [`SCC_AW-1:0] CNT_OFF = 8'(`SCC_OFF_T0CNT + t * `SCC_T_STRIDE);
         localparam logic [`SCC_AW-1:0] REL_OFF = 8'(`SCC_OFF_T0REL + t * `SCC_T_STRIDE);
         scc_pkg::scc_tmr_cfg_s tcfg;
         logic [`SCC_TW-1:0] cnt_ff, rel_ff;
         logic ovf_ff, fresh_ff, ext_prev_ff, src_hit;
         wire wr_cnt = w_glb & (w_off == CNT_OFF);
         wire wr_rel = w_glb & (w_off == REL_OFF);
         wire ext_hit = ext_count_in[t] & ~ext_prev_ff;
         wire tick = tcfg.run & src_hit;
         wire wrap = (cnt_ff == {`SCC_TW{1'b1}});

         assign tcfg = scc_pkg::scc_tmr_cfg_s'(tctrl_ff[t*`SCC_TC_STRIDE +: `SCC_TC_W]);

         always_comb
         begin
            unique case (tcfg.src)
               scc_pkg::SCC_DIV1: src_hit = stag ? hit8 : 1'b1;
               scc_pkg::SCC_DIV8: src_hit = hit8;
               scc_pkg::SCC_DIV64: src_hit = hit64;
               scc_pkg::SCC_DIV512: src_hit = hit512;
               scc_pkg::SCC_GPT: src_hit = gpt_hit;
               scc_pkg::SCC_EXT: src_hit = ext_hit;
               default: src_hit = 1'b0;
            endcase
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               cnt_ff <= '0;
               rel_ff <= '0;
               ovf_ff <= 1'b0;
               fresh_ff <= 1'b0;
               ext_prev_ff <= 1'b0;
            end
            else if (ce)
            begin
               ext_prev_ff <= ext_count_in[t];
               ovf_ff <= tick & wrap & ~wr_cnt;
               fresh_ff <= tick & ~wr_cnt;
               if (wr_rel)
                  rel_ff <= `SCC_TW'(merge(32'(rel_ff), w_data_ff, wmask));
               if (wr_cnt)
                  cnt_ff <= `SCC_TW'(merge(32'(cnt_ff), w_data_ff, wmask));
               else if (tick)
                  cnt_ff <= wrap ? rel_ff : cnt_ff + 1'b1;
            end
         end

         assign tcnt[t] = cnt_ff;
         assign trel[t] = rel_ff;
         assign tfresh[t] = fresh_ff;
         assign tovf[t] = ovf_ff;
      end
   endgenerate

   // ----------------------------------------------------------------
   // capture/compare channels
   // ----------------------------------------------------------------
   wire [`SCC_CFG_W-1:0] cfg_w [`SCC_NCH];
   wire [`SCC_TW-1:0] val_w [`SCC_NCH];
   wire [`SCC_NCH-1:0] match_w;

   genvar i;
   generate
      for (i = 0; i < `SCC_NCH; i++)
      begin : g_ch
         scc_pkg::scc_ch_cfg_s cfg_ff;
         logic [`SCC_TW-1:0] val_ff;
         logic prev_ff, pin_ff, oe_n_ff, irq_ff, spent_ff, done_ff;
         logic dbl_own, dbl_sub, peer;
         wire [`SCC_TW-1:0] tv = tcnt[cfg_ff.tsel];
         wire md_cap = (cfg_ff.mode == scc_pkg::SCC_CAP);
         wire md_c1 = (cfg_ff.mode == scc_pkg::SCC_CMP1);
         wire md_c3 = (cfg_ff.mode == scc_pkg::SCC_CMP3);
         wire once = (cfg_ff.mode == scc_pkg::SCC_CMP2) | md_c3;
         wire is_cmp = (cfg_ff.mode == scc_pkg::SCC_CMP0) | md_c1 | once;
         wire ovf = tovf[cfg_ff.tsel];
         // only a fresh timer step counts, so a stopped timer cannot match every cycle
         wire match = is_cmp & tfresh[cfg_ff.tsel] & (tv == val_ff) & ~spent_ff & ~(once & done_ff);
         wire rise = cc_pin_in[i] & ~prev_ff;
         wire fall = ~cc_pin_in[i] & prev_ff;
         wire cap = md_cap & ((cfg_ff.edge_sel[0] & rise) | (cfg_ff.edge_sel[1] & fall));
         wire wr_cfg = wr_do & (w_reg == `SCC_REG_CFG) & (w_idx == i);
         wire wr_val = wr_do & (w_reg == `SCC_REG_VAL) & (w_idx == i);
         wire tgl = dbl_own ? (match | peer) : (md_c1 & match);
         wire set3 = ~dbl_own & md_c3 & match;
         wire clr3 = ~dbl_own & md_c3 & ovf;
         wire drive = ~dbl_sub & (dbl_own | md_c1 | md_c3);

         if (i < `SCC_NPAIR)
         begin : g_pri
            assign dbl_own = dbl_ff[i];
            assign dbl_sub = 1'b0;
            assign peer = match_w[i+`SCC_NPAIR];
         end
         else
         begin : g_sec
            assign dbl_own = 1'b0;
            assign dbl_sub = dbl_ff[i-`SCC_NPAIR];
            assign peer = 1'b0;
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               cfg_ff <= '0;
               val_ff <= '0;
               prev_ff <= 1'b0;
               pin_ff <= 1'b0;
               oe_n_ff <= 1'b1;
               irq_ff <= 1'b0;
               spent_ff <= 1'b0;
               done_ff <= 1'b0;
            end
            else if (ce)
            begin
               prev_ff <= cc_pin_in[i];
               if (wr_cfg)
                  cfg_ff <= scc_pkg::scc_ch_cfg_s'(`SCC_CFG_W'(merge(32'(cfg_ff), w_data_ff, wmask)));
               if (cap)
                  val_ff <= tv;
               else if (wr_val)
                  val_ff <= `SCC_TW'(merge(32'(val_ff), w_data_ff, wmask));
               // new event beats a reconfiguration in the same cycle
               spent_ff <= (match & cfg_ff.single) | (spent_ff & ~wr_cfg);
               done_ff <= match | (done_ff & ~ovf);
               irq_ff <= cap | match;
               oe_n_ff <= ~drive;
               if (tgl)
                  pin_ff <= ~pin_ff;
               else if (set3)
                  pin_ff <= 1'b1;
               else if (clr3)
                  pin_ff <= 1'b0;
            end
         end

         assign match_w[i] = match;
         assign cfg_w[i] = cfg_ff;
         assign val_w[i] = val_ff;
         assign cc_pin_out[i] = pin_ff;
         assign cc_pin_oe_n[i] = oe_n_ff;
         assign cc_irq_req[i] = irq_ff;
      end
   endgenerate

   // ----------------------------------------------------------------
   // read selection
   // ----------------------------------------------------------------
   wire [31:0] glb_rd =
      (r_off == `SCC_OFF_TCTRL) ? 32'(tctrl_ff) :
      (r_off == `SCC_OFF_T0CNT) ? 32'(tcnt[0]) :
      (r_off == `SCC_OFF_T0REL) ? 32'(trel[0]) :
      (r_off == 8'(`SCC_OFF_T0CNT + `SCC_T_STRIDE)) ? 32'(tcnt[1]) :
      (r_off == 8'(`SCC_OFF_T0REL + `SCC_T_STRIDE)) ? 32'(trel[1]) :
      (r_off == `SCC_OFF_DBL) ? 32'(dbl_ff) :
      (r_off == `SCC_OFF_PINS) ? {cc_pin_in, cc_pin_out} : '0;
   assign rd_data =
      ~r_map ? '0 :
      (r_reg == `SCC_REG_CFG) ? 32'(cfg_w[r_idx]) :
      (r_reg == `SCC_REG_VAL) ? 32'(val_w[r_idx]) : glb_rd;
endmodule
`default_nettype wire

// ---- scc_pins_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module scc_pins_model (
   input wire logic [15:0] pin_out,
   input wire logic [15:0] oe_n,
   input wire logic [15:0] drive,
   output logic [15:0] pin_in
);
   // a pin the unit drives reads back its own level, otherwise the outside source wins
   assign pin_in = (~oe_n & pin_out) | (oe_n & drive);
endmodule
`default_nettype wire

// ---- scc_assertions.sv ----
`timescale 1ns/10ps
`include "scc_cfg.svh"
`default_nettype none
module scc_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`SCC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`SCC_NCH-1:0] cc_pin_oe_n,
   input wire logic [`SCC_NCH-1:0] cc_irq_req
);
   // holes in the map: above the pin word, and above the value block
   wire logic ar_bad = (s_axi_araddr >= 8'h1c && s_axi_araddr <= 8'h3f) || s_axi_araddr >= 8'hc0;
   wire logic ar_take = s_axi_arvalid && s_axi_arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_reset_quiet:
      assert property (disable iff (1'b0) !aresetn |=> !s_axi_awready && !s_axi_arready && !s_axi_bvalid
         && !s_axi_rvalid && cc_pin_oe_n == '1 && cc_irq_req == '0) else $error("outputs live in reset");
   a_aw_drop:
      assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_w_drop:
      assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("wready held");
   // both words are parked for one cycle before the write runs, so the answer is two edges out
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
         |-> ##2 s_axi_bvalid) else $error("no write response");
   a_b_done:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
         else $error("write not closed");
   a_read_answer:
      assert property (ar_take |=> s_axi_rvalid && !s_axi_arready) else $error("no read data");
   a_ar_block:
      assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
   a_r_done:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
         else $error("read not closed");
   a_rd_err:
      assert property (ar_take && ar_bad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
         else $error("hole read not refused");
   a_rd_ok:
      assert property (ar_take && !ar_bad |=> s_axi_rresp == 2'h0) else $error("good read refused");
endmodule
bind scc_top scc_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cc_pin_oe_n, .cc_irq_req);
`default_nettype wire

// ---- scc_tb.sv ----
`timescale 1ns/10ps
`include "scc_cfg.svh"
`default_nettype none
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awa = 8'h0;
   logic [7:0] ara = 8'h0;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, gpt = 1'b0;
   logic [1:0] ext = 2'h0;
   logic [15:0] drv = 16'h0;
   logic awr, wrd, bv, arr, rvl;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rv;
   logic [15:0] pin_in, pin_out, oe_n, irq;
   logic [15:0] last = 16'h0;
   int n_errors = 0;
   int n_checks = 0;
   int irqs [16];
   int tog [16];
   int tc [5] = '{32'h1, 32'h3, 32'h5, 32'h7, 32'h10001};
   // the sysclk pass loses the 24 cycles in which ce is held low
   int dv [5] = '{1000, 128, 16, 2, 128};

   always #2.5 aclk = ~aclk;

   scc_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rrdy), .gpt_ovf_pulse(gpt),
      .ext_count_in(ext), .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe_n(oe_n), .cc_irq_req(irq));
   scc_pins_model pins (.pin_out, .oe_n, .drive(drv), .pin_in);

   // counted on the falling edge so the main sequence never races it
   always @(negedge aclk)
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (irq[i] === 1'b1)
            irqs[i]++;
         if (pin_out[i] !== last[i])
            tog[i]++;
      end
      last = pin_out;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awr === 1'b1)
            awv <= 1'b0;
         if (wrd === 1'b1)
            wv <= 1'b0;
      end while (bv !== 1'b1);
      brdy <= 1'b0;
      chk("bresp", 32'(er), 32'(bresp));
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arr === 1'b1)
            arv <= 1'b0;
      end while (rvl !== 1'b1);
      rrdy <= 1'b0;
      rv = rdata;
      chk("rresp", 32'(er), 32'(rresp));
   endtask

   function automatic logic [7:0] ra(input logic [7:0] b, input int i);
      return b + 8'(4 * i);
   endfunction

   function automatic logic [31:0] cf(input scc_pkg::scc_mode_e m, input logic [1:0] e, input logic t,
      input logic s);
      scc_pkg::scc_ch_cfg_s c;
      c = '{single: s, tsel: t, edge_sel: e, mode: m};
      return {25'h0, c};
   endfunction

   task automatic chan(input int i, input logic [31:0] c, input logic [15:0] v);
      wr(ra(8'h40, i), c, 2'h0);
      wr(ra(8'h80, i), 32'(v), 2'h0);
   endtask

   task automatic setpin(input int i, input logic v);
      @(posedge aclk);
      drv[i] <= v;
      repeat (4) @(posedge aclk);
   endtask

   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   //--------------------------------------------------------------
   // main sequence
   //--------------------------------------------------------------
   initial
   begin
      int n;
      logic [15:0] c;
      int si [16];
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SCC_OFF_TCTRL, 2'h0);
      chk("tctrl", 32'h0, rv);
      chk("oe_n", 32'hffff, 32'(oe_n));
      rd(8'h1c, 2'h2);
      chk("hole", 32'h0, rv);
      wr(8'hc0, 32'h1, 2'h2);
      wr(`SCC_OFF_PINS, 32'h1, 2'h0);
      // stopped timers give a known count to capture
      for (int e = 1; e < 4; e++)
      begin
         n = irqs[2];
         wr(8'h04, 32'h100 + e, 2'h0);
         wr(8'h0c, 32'h200 + e, 2'h0);
         wr(ra(8'h40, 2), cf(scc_pkg::SCC_CAP, 2'(e), 1'(e == 2), 1'b0), 2'h0);
         setpin(2, 1'b1);
         setpin(2, 1'b0);
         chk("cap irq", 32'((e & 1) + (e >> 1)), 32'(irqs[2] - n));
         rd(ra(8'h80, 2), 2'h0);
         chk("cap val", (e == 2 ? 32'h200 : 32'h100) + e, rv);
      end
      wr(8'h08, 32'hfff0, 2'h0);
      wr(8'h04, 32'hfff0, 2'h0);
      wr(8'h10, 32'hfff8, 2'h0);
      wr(8'h0c, 32'hfff8, 2'h0);
      wr(`SCC_OFF_DBL, 32'h40, 2'h0);
      chan(0, cf(scc_pkg::SCC_CMP0, 2'h0, 1'b0, 1'b0), 16'hfff4);
      chan(1, cf(scc_pkg::SCC_CMP1, 2'h0, 1'b0, 1'b0), 16'hfff8);
      chan(4, cf(scc_pkg::SCC_CMP3, 2'h0, 1'b0, 1'b0), 16'hfffa);
      chan(5, cf(scc_pkg::SCC_CMP0, 2'h0, 1'b0, 1'b1), 16'hfff4);
      chan(6, cf(scc_pkg::SCC_CMP0, 2'h0, 1'b0, 1'b0), 16'hfff2);
      chan(7, cf(scc_pkg::SCC_CMP2, 2'h0, 1'b0, 1'b0), 16'hfff4);
      chan(8, cf(scc_pkg::SCC_CMP0, 2'h0, 1'b1, 1'b0), 16'hfffc);
      chan(14, cf(scc_pkg::SCC_CMP0, 2'h0, 1'b0, 1'b0), 16'hfffc);
      chk("oe_n", 32'hffad, 32'(oe_n));
      wr(`SCC_OFF_TCTRL, 32'h0101, 2'h0);
      repeat (20) @(posedge aclk);
      si = irqs;
      n = tog[1] + 100 * tog[4] + 10000 * tog[6];
      // 64 steps are four periods of timer 0 and eight of timer 1
      repeat (64) @(posedge aclk);
      chk("cmp0", 32'h4, 32'(irqs[0] - si[0]));
      chk("cmp1 irq", 32'h4, 32'(irqs[1] - si[1]));
      chk("cmp2", 32'h4, 32'(irqs[7] - si[7]));
      chk("timer1", 32'h8, 32'(irqs[8] - si[8]));
      chk("toggles", 32'd80804, 32'(tog[1] + 100 * tog[4] + 10000 * tog[6] - n));
      chk("single", 32'h1, 32'(irqs[5]));
      // switch sources first, or the running timers creep past the cleared counts
      wr(`SCC_OFF_TCTRL, 32'h0b09, 2'h0);
      wr(8'h08, 32'h0, 2'h0);
      wr(8'h04, 32'h0, 2'h0);
      wr(8'h0c, 32'h0, 2'h0);
      for (int k = 0; k < 5; k++)
      begin
         @(posedge aclk);
         gpt <= 1'(k < 3);
         ext[1] <= 1'b1;
         repeat (2) @(posedge aclk);
         gpt <= 1'b0;
         ext[1] <= 1'b0;
         repeat (2) @(posedge aclk);
      end
      repeat (4) @(posedge aclk);
      rd(8'h04, 2'h0);
      chk("gpt count", 32'h3, rv);
      rd(8'h0c, 2'h0);
      chk("ext count", 32'h5, rv);
      // read-to-read spacing is 1024 cycles, so each divider gives a whole tick count
      for (int k = 0; k < 5; k++)
      begin
         wr(`SCC_OFF_TCTRL, 32'(tc[k]), 2'h0);
         rd(8'h04, 2'h0);
         c = rv[15:0];
         ce <= 1'(k != 0);
         repeat (24) @(posedge aclk);
         ce <= 1'b1;
         repeat (997) @(posedge aclk);
         rd(8'h04, 2'h0);
         chk("ticks", 32'(dv[k]), 32'(16'(rv[15:0] - c)));
      end
      results();
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      $display("MISMATCH watchdog expected done seen timeout");
      results();
   end
endmodule
`default_nettype wire
